// ===== cal_cmd_core.sv
// Command interpreter for calibration, synchronise, standby, resume and reset.
// Assumes sclk is the host's serial clock (second domain), cs_n/din from pins,
// master_clock_in sampled from a pin, and a converter that reports measurements.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Offset self-cal runs internally then loads the offset calibration register.
// - Gain self-cal runs internally then loads the gain calibration register.
// - System offset cal measures external input then updates offset register.
// - System gain cal measures external input then updates gain register.
// - Ready goes high at calibration start, low when settled data exists.
// - Sync fires on first master clock rise after resume's first serial edge; the code arms on the first serial edge of any byte after sync.
// - Standby command enters low power and stays there until woken.
// - Serial clocking with select high does not leave standby.
// - Resume command ends standby; host uses it to do so.
// - Standby plus resume gives one conversion then low power again.
// - Resume accepted as all zeros or all ones, treated alike.
// - Reset restores defaults except the clock output rate bits.
// - Reset ends continuous read; host sends it after ready falls.
// - Resume decodes from opcode 00h or FFh.
// - These commands are single stand-alone bytes.
module cal_cmd_core
  import cal_cmd_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  // Core clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial link from the host.
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  // Master clock pin.
  input  wire logic        master_clock_in,
  // Converter measurement and done pulse.
  input  wire logic [23:0] measured_value,
  input  wire logic        conv_done,
  // Status and registers.
  output logic             result_ready_n,
  output logic             standby_mode,
  output logic             sync_pulse,
  output logic             continuous_read_mode,
  output logic [23:0]      offset_cal_reg,
  output logic [23:0]      gain_cal_reg,
  output logic [7:0]       converter_control_reg
);

  typedef enum logic [2:0] {ST_IDLE, ST_CAL, ST_SETTLE, ST_STANDBY, ST_ONESHOT} state_t;

  // Cycles from the first calibration cycle to the load cycle.
  localparam int CAL_LAST = CAL_CYCLES - 1;

  // Link domain: shift register, bit count and byte toggle.
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [7:0] byte_q;
  logic       byte_tgl_q;
  logic       first_edge_tgl_q;
  logic [7:0] shift_d;

  assign shift_d = {shift_q[6:0], din};

  // Capture bytes MSB first while select is low; idle select resets framing.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_q <= 3'd0;
    end else begin
      bit_q <= bit_q + 3'd1;
    end
  end

  // Data shift and byte hand-off; the byte holds until the next full byte.
  always_ff @(posedge sclk) begin
    shift_q <= shift_d;
    if (!cs_n && bit_q == 3'd7) begin
      byte_q <= shift_d;
    end
  end

  // Byte and first-edge toggles start at zero so no false event follows reset.
  // The serial clock is idle during reset, so the release cannot race an edge.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      byte_tgl_q       <= 1'b0;
      first_edge_tgl_q <= 1'b0;
    end else begin
      if (!cs_n && bit_q == 3'd7) begin
        byte_tgl_q <= ~byte_tgl_q;
      end
      if (!cs_n && bit_q == 3'd0) begin
        first_edge_tgl_q <= ~first_edge_tgl_q;
      end
    end
  end

  // Core domain synchronisers for toggles, select and master clock.
  logic [2:0] byte_sync_q;
  logic [2:0] edge_sync_q;
  logic [1:0] cs_sync_q;
  logic [2:0] mclk_sync_q;
  logic [7:0] cmd_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      byte_sync_q <= 3'b000;
      edge_sync_q <= 3'b000;
      cs_sync_q   <= 2'b11;
      mclk_sync_q <= 3'b000;
    end else begin
      byte_sync_q <= {byte_sync_q[1:0], byte_tgl_q};
      edge_sync_q <= {edge_sync_q[1:0], first_edge_tgl_q};
      cs_sync_q   <= {cs_sync_q[0], cs_n};
      mclk_sync_q <= {mclk_sync_q[1:0], master_clock_in};
    end
  end

  // Byte data is stable when its toggle arrives.
  wire byte_evt  = byte_sync_q[2] ^ byte_sync_q[1];
  wire edge_evt  = edge_sync_q[2] ^ edge_sync_q[1];
  wire mclk_rise = mclk_sync_q[1] & ~mclk_sync_q[2];
  wire cs_low    = ~cs_sync_q[1];

  always_ff @(posedge clk) begin
    cmd_q <= byte_q;
  end

  // Command decode.
  state_t      state_q;
  state_t      state_d;
  logic [1:0]  cal_kind_q;
  logic [15:0] cal_cnt_q;
  logic        sync_pend_q;
  logic        sync_arm_q;
  logic        one_shot_q;

  wire busy        = (state_q == ST_CAL) || (state_q == ST_SETTLE);
  wire cmd_evt     = byte_evt && !busy;
  wire [7:0] cmd   = cmd_q;
  wire is_resume   = (cmd == OP_RESUME_ZERO) || (cmd == OP_RESUME_ONE);
  wire is_cal_off  = (cmd == OP_SELF_OFFSET) || (cmd == OP_SYS_OFFSET) || (cmd == OP_SELF_CAL_BOTH);
  wire is_cal_gain = (cmd == OP_SELF_GAIN) || (cmd == OP_SYS_GAIN) || (cmd == OP_SELF_CAL_BOTH);
  wire is_cal      = is_cal_off || is_cal_gain;
  wire is_reset    = cmd == OP_RESET;
  wire cal_end     = (state_q == ST_CAL) && (cal_cnt_q == 16'(CAL_CYCLES - 1));
  // The first serial edge of any byte while standby waits and select is low wakes it.
  wire stray_wake  = edge_evt && cs_low && (state_q == ST_STANDBY);

  // Next-state selection; every command is one stand-alone byte.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_evt && is_cal) begin
          state_d = ST_CAL;
        end else if (cmd_evt && cmd == OP_STANDBY) begin
          state_d = ST_STANDBY;
        end
      end
      ST_CAL: begin
        if (cal_end) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (conv_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_STANDBY: begin
        if ((cmd_evt && is_resume) || stray_wake) begin
          state_d = ST_ONESHOT;
        end
      end
      ST_ONESHOT: begin
        if (conv_done) begin
          state_d = one_shot_q ? ST_STANDBY : ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (cmd_evt && is_reset) begin
      state_d = ST_IDLE;
    end
  end

  // State, calibration counter and kind.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      cal_cnt_q  <= 16'h0000;
      cal_kind_q <= 2'b00;
      one_shot_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cal_cnt_q <= (state_q == ST_CAL) ? cal_cnt_q + 16'h0001 : 16'h0000;
      if (cmd_evt && is_cal && state_q == ST_IDLE) begin
        cal_kind_q <= {is_cal_gain, is_cal_off};
      end
      if (state_q == ST_STANDBY && state_d == ST_ONESHOT) begin
        one_shot_q <= 1'b1;
      end else if (state_q == ST_IDLE || (cmd_evt && is_reset)) begin
        one_shot_q <= 1'b0;
      end
    end
  end

  // Calibration register loads and reset restore.
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_cal_reg        <= OFFSET_CAL_RST;
      gain_cal_reg          <= GAIN_CAL_RST;
      converter_control_reg <= CONV_CTRL_RST;
    end else if (cmd_evt && is_reset) begin
      offset_cal_reg <= OFFSET_CAL_RST;
      gain_cal_reg   <= GAIN_CAL_RST;
      converter_control_reg <= (CONV_CTRL_RST & ~(8'h03 << CLK_RATE_LSB))
                             | (converter_control_reg & (8'h03 << CLK_RATE_LSB));
    end else if (cal_end) begin
      if (cal_kind_q[0]) begin
        offset_cal_reg <= measured_value;
      end
      if (cal_kind_q[1]) begin
        gain_cal_reg <= measured_value;
      end
    end
  end

  // Sync request: set by sync, armed by the first edge of the next byte of any kind, fired on the next master clock rise.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_pend_q <= 1'b0;
      sync_arm_q  <= 1'b0;
      sync_pulse  <= 1'b0;
    end else begin
      sync_pulse <= 1'b0;
      if (cmd_evt && is_reset) begin
        sync_pend_q <= 1'b0;
        sync_arm_q  <= 1'b0;
      end else if (cmd_evt && cmd == OP_SYNC) begin
        sync_pend_q <= 1'b1;
        sync_arm_q  <= 1'b0;
      end else if (sync_pend_q && edge_evt) begin
        sync_arm_q <= 1'b1;
      end
      if (sync_arm_q && mclk_rise && !(cmd_evt && is_reset)) begin
        sync_pulse  <= 1'b1;
        sync_pend_q <= 1'b0;
        sync_arm_q  <= 1'b0;
      end
    end
  end

  // Continuous read mode and data ready output.
  always_ff @(posedge clk) begin
    if (rst) begin
      continuous_read_mode <= 1'b0;
      result_ready_n       <= 1'b1;
    end else begin
      if (cmd_evt && (is_reset || cmd == OP_STOP_CONT_READ)) begin
        continuous_read_mode <= 1'b0;
      end else if (cmd_evt && cmd == OP_CONT_READ) begin
        continuous_read_mode <= 1'b1;
      end
      if (state_d == ST_CAL || state_d == ST_SETTLE) begin
        result_ready_n <= 1'b1;
      end else if (conv_done) begin
        result_ready_n <= 1'b0;
      end
    end
  end

  assign standby_mode = (state_q == ST_STANDBY);

  // Ready must be high for the whole calibration.
  ready_high_cal_a: assert property (@(posedge clk) disable iff (rst)
    busy |-> result_ready_n) else $error("Ready low during calibration.");

  // Calibration ends after the fixed count.
  cal_length_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_CAL && cal_cnt_q == 16'h0000) |-> ##CAL_LAST cal_end)
    else $error("Calibration length wrong.");

  // Offset load takes the measured value.
  offset_load_a: assert property (@(posedge clk) disable iff (rst)
    (cal_end && cal_kind_q[0] && !(cmd_evt && is_reset)) |=> offset_cal_reg == $past(measured_value))
    else $error("Offset register not loaded.");

  // Gain load takes the measured value.
  gain_load_a: assert property (@(posedge clk) disable iff (rst)
    (cal_end && cal_kind_q[1] && !(cmd_evt && is_reset)) |=> gain_cal_reg == $past(measured_value))
    else $error("Gain register not loaded.");

  // Reset keeps clock rate bits.
  reset_keep_rate_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_evt && is_reset) |=> converter_control_reg[CLK_RATE_LSB +: 2] == $past(converter_control_reg[CLK_RATE_LSB +: 2]))
    else $error("Clock rate bits changed by reset.");

  // Reset clears sync and continuous read.
  reset_clears_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_evt && is_reset) |=> !sync_pend_q && !continuous_read_mode)
    else $error("Reset left state pending.");

  // Sync pulse only on a master clock rise after arming.
  sync_edge_a: assert property (@(posedge clk) disable iff (rst)
    sync_pulse |-> $past(sync_arm_q) && $past(mclk_rise))
    else $error("Sync pulse at wrong time.");

  // Resume ends standby on the next cycle.
  resume_exit_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_STANDBY && ((cmd_evt && is_resume) || stray_wake)) |=> state_q == ST_ONESHOT)
    else $error("Resume did not end standby.");

  // Bytes during calibration do not disturb it.
  busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_CAL && !cal_end) |=> state_q == ST_CAL)
    else $error("Calibration disturbed.");

  // A calibration byte in idle starts calibration with ready high.
  cal_start_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && cmd_evt && is_cal) |=> (state_q == ST_CAL) && result_ready_n)
    else $error("Calibration did not start.");

  // Ready falls once settled data follows calibration.
  ready_low_done_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_SETTLE && conv_done) |=> !result_ready_n && state_q == ST_IDLE)
    else $error("Ready did not fall after settle.");

  // The standby byte in idle enters standby.
  standby_enter_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_IDLE && cmd_evt && cmd == OP_STANDBY && !is_cal) |=> standby_mode)
    else $error("Standby not entered.");

  // Standby holds while no resume, reset or selected clock arrives.
  standby_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_STANDBY && !edge_evt && !byte_evt) |=> standby_mode)
    else $error("Standby left without cause.");

  // A one-shot conversion returns to standby.
  one_shot_ret_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_ONESHOT && one_shot_q && conv_done && !(cmd_evt && is_reset)) |=> standby_mode)
    else $error("One-shot did not return to standby.");

endmodule : cal_cmd_core

`default_nettype wire

// ===== cal_cmd_pkg.sv
// Constants for the calibration, synchronise, standby and reset command block.
// Assumes a byte-wide serial command link from a host and a 250 MHz core clock.
package cal_cmd_pkg;

  // Stand-alone command opcodes.
  localparam logic [7:0] OP_RESUME_ZERO    = 8'h00;
  localparam logic [7:0] OP_RESUME_ONE     = 8'hFF;
  localparam logic [7:0] OP_CONT_READ      = 8'h03;
  localparam logic [7:0] OP_STOP_CONT_READ = 8'h0F;
  localparam logic [7:0] OP_SELF_CAL_BOTH  = 8'hF0;
  localparam logic [7:0] OP_SELF_OFFSET    = 8'hF1;
  localparam logic [7:0] OP_SELF_GAIN      = 8'hF2;
  localparam logic [7:0] OP_SYS_OFFSET     = 8'hF3;
  localparam logic [7:0] OP_SYS_GAIN       = 8'hF4;
  localparam logic [7:0] OP_SYNC           = 8'hFC;
  localparam logic [7:0] OP_STANDBY        = 8'hFD;
  localparam logic [7:0] OP_RESET          = 8'hFE;

  // Reset values.
  localparam logic [23:0] OFFSET_CAL_RST  = 24'h00_0000;
  localparam logic [23:0] GAIN_CAL_RST    = 24'h40_0000;
  localparam logic [7:0]  CONV_CTRL_RST   = 8'h20;
  localparam int          CLK_RATE_LSB    = 5;
  localparam logic [1:0]  CLK_RATE_MASKED = 2'b00;

  // Default calibration length in core clock cycles.
  localparam int CAL_CYCLES_DEF = 64;

endpackage : cal_cmd_pkg

// ===== host_link_model.sv
// Host serial master model: shifts stand-alone command bytes MSB first.
// Assumes the device samples din on sclk rising edges while cs_n is low.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Serial link to the device.
  output var logic sclk,
  output var logic cs_n,
  output var logic din
);
  // Idle link: select high and clock still outside frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // Shifts one whole byte under one select window, then parks data inverted.
  task automatic send_byte(input logic [7:0] op);
    cs_n = 1'b0;
    #15;
    for (int i = 7; i >= 0; i--) begin
      din = op[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #15 cs_n = 1'b1;
    din = ~din;
    #60;
  endtask

  // Toggles sclk n times under the given select level, outside any command.
  task automatic stray_clocks(input logic sel_n, input int n);
    cs_n = sel_n;
    repeat (n) begin
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
      din = ~din;
    end
    #15 cs_n = 1'b1;
    #60;
  endtask
endmodule // host_link_model
`default_nettype wire

// ===== test_adc_cal_sync_standby_cmds.sv
// Self-checking bench for the command interpreter with a host link model.
// Assumes a 4 ns core clock and a shortened calibration length.
`timescale 1ns/1ps
`default_nettype none
module test_adc_cal_sync_standby_cmds;
  import cal_cmd_pkg::*;
  localparam int CAL_N = 16;
  logic        clk, rst, sclk, cs_n, din, master_clock_in, conv_done;
  logic [23:0] measured_value, offset_cal_reg, gain_cal_reg, exp_off, exp_gain;
  logic        result_ready_n, standby_mode, sync_pulse, continuous_read_mode;
  logic [7:0]  converter_control_reg;
  int          failures, n_compared, sync_count;

  host_link_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din));

  cal_cmd_core #(.CAL_CYCLES(CAL_N)) dut_u (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .master_clock_in(master_clock_in), .measured_value(measured_value),
    .conv_done(conv_done), .result_ready_n(result_ready_n),
    .standby_mode(standby_mode), .sync_pulse(sync_pulse),
    .continuous_read_mode(continuous_read_mode), .offset_cal_reg(offset_cal_reg),
    .gain_cal_reg(gain_cal_reg), .converter_control_reg(converter_control_reg));

  // Core clock and a count of cycles with the sync pulse high.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (sync_pulse === 1'b1) sync_count++;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic pulse_done();
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
  endtask

  // Calibration: ready high, stray byte ignored, offset, gain or both registers loaded, ready low after settle.
  task automatic cal_case(input logic [7:0] op, input logic [23:0] val, input logic is_gain);
    measured_value = val;
    host_u.send_byte(op);
    check("ready_busy", 24'(result_ready_n), 24'h00_0001);
    host_u.send_byte(OP_STANDBY);
    check("stby_ignored", 24'(standby_mode), 24'h00_0000);
    if (is_gain) exp_gain = val;
    else exp_off = val;
    if (op == OP_SELF_CAL_BOTH) exp_off = val;
    check("offset_reg", offset_cal_reg, exp_off);
    check("gain_reg", gain_cal_reg, exp_gain);
    check("ready_settle", 24'(result_ready_n), 24'h00_0001);
    pulse_done();
    for (int i = 0; i < 20 && result_ready_n !== 1'b0; i++) tick(1);
    check("ready_done", 24'(result_ready_n), 24'h00_0000);
  endtask

  // Sync then a middle byte then resume; one master clock rise afterwards.
  task automatic sync_case(input logic [7:0] mid, input logic [7:0] resume, input int exp_n);
    int base;
    base = sync_count;
    host_u.send_byte(OP_SYNC);
    host_u.send_byte(mid);
    host_u.send_byte(resume);
    check("sync_early", 24'(sync_count - base), 24'h00_0000);
    master_clock_in = 1'b1;
    tick(8);
    master_clock_in = 1'b0;
    tick(2);
    check("sync_count", 24'(sync_count - base), 24'(exp_n));
  endtask

  // Continuous read on and off, then reset command restores defaults.
  task automatic reset_case();
    host_u.send_byte(OP_CONT_READ);
    check("cont_on", 24'(continuous_read_mode), 24'h00_0001);
    host_u.send_byte(OP_STOP_CONT_READ);
    check("cont_off", 24'(continuous_read_mode), 24'h00_0000);
    host_u.send_byte(OP_CONT_READ);
    host_u.send_byte(OP_RESET);
    check("cont_reset", 24'(continuous_read_mode), 24'h00_0000);
    check("off_reset", offset_cal_reg, OFFSET_CAL_RST);
    check("gain_reset", gain_cal_reg, GAIN_CAL_RST);
    check("ctrl_reset", 24'(converter_control_reg), 24'(CONV_CTRL_RST));
    exp_off = OFFSET_CAL_RST;
    exp_gain = GAIN_CAL_RST;
  endtask

  // Standby, tolerated clocks, wake on the first edge of each resume byte (both opcodes) with one-shot return.
  task automatic standby_case();
    host_u.send_byte(OP_STANDBY);
    check("stby_on", 24'(standby_mode), 24'h00_0001);
    host_u.stray_clocks(1'b1, 8);
    check("stby_cs_high", 24'(standby_mode), 24'h00_0001);
    for (int k = 0; k < 2; k++) begin
      host_u.send_byte(k == 0 ? OP_RESUME_ZERO : OP_RESUME_ONE);
      check("stby_resume", 24'(standby_mode), 24'h00_0000);
      pulse_done();
      tick(4);
      check("one_shot", 24'(standby_mode), 24'h00_0001);
    end
    host_u.stray_clocks(1'b0, 2);
    check("stby_cs_low", 24'(standby_mode), 24'h00_0000);
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    master_clock_in = 1'b0;
    conv_done = 1'b0;
    measured_value = 24'h00_0000;
    failures = 0;
    n_compared = 0;
    sync_count = 0;
    exp_off = OFFSET_CAL_RST;
    exp_gain = GAIN_CAL_RST;
    tick(8);
    rst = 1'b0;
    tick(8);
    check("off_init", offset_cal_reg, OFFSET_CAL_RST);
    check("gain_init", gain_cal_reg, GAIN_CAL_RST);
    check("ctrl_init", 24'(converter_control_reg), 24'(CONV_CTRL_RST));
    cal_case(OP_SELF_OFFSET, 24'h12_3456, 1'b0);
    cal_case(OP_SELF_GAIN, 24'h3A_5A5A, 1'b1);
    cal_case(OP_SYS_OFFSET, 24'h00_0F0F, 1'b0);
    cal_case(OP_SYS_GAIN, 24'h44_1122, 1'b1);
    cal_case(OP_SELF_CAL_BOTH, 24'h21_4365, 1'b1);
    sync_case(OP_SYNC, OP_RESUME_ZERO, 1);
    sync_case(OP_SYNC, OP_RESUME_ONE, 1);
    sync_case(OP_RESET, OP_RESUME_ZERO, 0);
    reset_case();
    standby_case();
    finish_test();
  end

  // Watchdog against a hung run.
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule // test_adc_cal_sync_standby_cmds
`default_nettype wire
